// >>> core/sroei_core.sv
// Receiver output stage: serial audio formatter, C/U/V and block flag, concealment, error and interrupt pins.
// Assumes decoded samples arrive as single-cycle strobes on clk and the recovered bit clock is an asynchronous pin.
//
// Overview of operation
// [RULE_01] Format select picks RJ24, RJ16, I2S or LJ24
// [RULE_02] Samples go out MSB first, two's complement
// [RULE_03] C, U, V outputs track the frame clock
// [RULE_04] Frame clock polarity follows selected format
// [RULE_05] Block start raises flag for eight frames
// [RULE_06] Frames numbered 0 to 191 per block
// [RULE_07] Validity rises immediately or at sample start
// [RULE_08] PCM parity error repeats previous good sample
// [RULE_09] Non-PCM samples pass unchanged, no repetition
// [RULE_10] Policy 01: mute after eight errors, PCM
// [RULE_11] Policy 10: same, for PCM and non-PCM
// [RULE_12] Policy 00 ignores errors; 11 reserved
// [RULE_13] Status pins: flag, interrupt, or released
// [RULE_14] Interrupt is OR of unmasked pending bits
// [RULE_15] Status read clears bits and interrupt pin
// [RULE_16] Masks reset to all sources masked
// [RULE_17] Error flag ORs enabled sources; unlock default
// [RULE_18] Eight interrupt sources, analog only on b
// [RULE_19] Host reads status to find and clear
// [RULE_20] Unlisted format codes behave as I2S
// [RULE_21] Good sample clears error run and mute
//
// Local design decision: register access over Wishbone.
`default_nettype none
module sroei_core
  import sroei_pkg::*;
(
  input wire logic clk, // 200 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [9:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic rx_bit_clk, // Recovered 64fs bit clock pin
  input wire logic smp_valid, // Decoded sample strobe
  input wire logic smp_right, // Sample belongs to right channel
  input wire logic [23:0] smp_data, // Decoded sample, two's complement
  input wire logic smp_parity_err, // Sample had a parity error
  input wire logic smp_c, // Channel status bit of sample
  input wire logic smp_u, // User bit of sample
  input wire logic smp_v, // Validity bit of sample
  input wire logic smp_block_start, // Sample followed a block-start preamble
  input wire logic pll_unlock, // Receiver PLL not locked
  input wire logic rate_out_of_range, // Incoming rate outside limits
  input wire logic rate_change_ev, // Pulse: incoming rate changed
  input wire logic emphasis_ev, // Pulse: emphasis flag seen
  input wire logic surround_ev, // Pulse: compressed-disc surround found
  input wire logic cs_update_ev, // Pulse: channel status updated
  input wire logic burst_update_ev, // Pulse: burst preamble updated
  input wire logic analog_level_ev, // Pulse: analog level crossed
  output logic serial_data_out, // Serial audio data
  output logic recovered_frame_clock_out, // Frame clock
  output logic channel_status_out, // Channel status bit
  output logic user_bits_out, // User bit
  output logic validity_out, // Validity bit
  output logic block_start_flag, // Block start flag
  output logic interrupt_line_a, // Pin a level
  output logic interrupt_line_a_oe_n, // Pin a enable, low drives
  output logic interrupt_line_b, // Pin b level
  output logic interrupt_line_b_oe_n // Pin b enable, low drives
);
  // Register file
  logic validity_timing_select_r; // 0 immediate, 1 at sample start
  logic [1:0] parity_error_policy_r; // Concealment policy
  logic [7:0] err_en_r; // Error source enables
  logic [7:0] mask_a_r, mask_b_r; // Interrupt masks
  logic [7:0] stat_a_r, stat_b_r; // Pending interrupt bits
  logic [3:0] pin_mode_r; // Pin functions, b in [3:2], a in [1:0]
  logic [2:0] output_format_select_r; // Format code
  // Bus
  logic bus_req; // New request this cycle
  logic [7:0] idx; // Register index
  logic rd_a, rd_b; // Status reads being answered
  // Receive side
  logic [7:0] fidx_r; // Frame number of last left sample
  logic [7:0] fidx_nxt; // Frame number of arriving left sample
  logic nonaudio_flag; // Latched channel status bit 1
  logic [3:0] err_run_r; // Consecutive error count
  logic mute_r; // Output muted
  logic [23:0] good_l_r, good_r_r; // Last good sample per channel
  logic [23:0] conceal; // Sample after concealment
  logic conceal_on; // Policy covers this data type
  logic last_v_r, last_perr_r; // Latest validity and parity state
  logic [23:0] pend_l_r, pend_r_r; // Samples waiting for next frame
  logic [2:0] pend_cuv_l_r, pend_cuv_r_r; // C, U, V waiting
  logic pend_bs_r; // Block start waiting
  // Link side
  logic [2:0] bck_sync_r; // Bit clock synchroniser
  logic bck_fall; // Settled falling edge
  logic [5:0] slot_r; // Bit slot within the frame
  logic [5:0] slot_nxt; // Slot after this edge
  logic [2:0] fmt_eff; // Format with unlisted codes folded
  logic [4:0] start_slot; // First data slot of each half
  logic [23:0] shift_r; // Output shift register
  logic [23:0] out_l_r, out_r_r; // Current frame pair
  logic [2:0] cuv_l_r, cuv_r_r; // Current frame C, U, V
  logic [2:0] blk_cnt_r; // Frames left for block flag
  // Errors and interrupts
  logic err_flag; // Receiver error level
  logic err_flag_d_r, nonaudio_d_r; // Delayed for edge detect
  logic [7:0] ev_a, ev_b; // Interrupt events this cycle
  logic [7:0] stat_a_nxt, stat_b_nxt, mask_a_nxt, mask_b_nxt; // Next values
  logic irq_a_r, irq_b_r; // Interrupt levels

  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[9:2];
  assign rd_a = bus_req & ~wb_we_i & (idx == IDX_STAT_A);
  assign rd_b = bus_req & ~wb_we_i & (idx == IDX_STAT_B);

  // Acknowledge one cycle after the request, every address
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data; unmapped indices read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req & ~wb_we_i) begin
      case (idx)
        IDX_VALID_TIMING: wb_dat_o <= {31'h0, validity_timing_select_r};
        IDX_PARITY_POL: wb_dat_o <= {30'h0, parity_error_policy_r};
        IDX_ERR_SRC: wb_dat_o <= {24'h0, err_en_r};
        IDX_MASK_A: wb_dat_o <= {24'h0, mask_a_r};
        IDX_MASK_B: wb_dat_o <= {24'h0, mask_b_r};
        IDX_STAT_A: wb_dat_o <= {24'h0, stat_a_r}; // [RULE_19]
        IDX_STAT_B: wb_dat_o <= {24'h0, stat_b_r}; // [RULE_19]
        IDX_PIN_MODE: wb_dat_o <= {28'h0, pin_mode_r};
        IDX_FMT: wb_dat_o <= {29'h0, output_format_select_r};
        IDX_FRAME_STAT: wb_dat_o <= {14'h0, mute_r, nonaudio_flag, err_run_r, 4'h0, fidx_r};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Next masks from writes on byte lane 0
  always_comb begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    if (bus_req & wb_we_i & wb_sel_i[0] & (idx == IDX_MASK_A)) begin
      mask_a_nxt = wb_dat_i[7:0];
    end
    if (bus_req & wb_we_i & wb_sel_i[0] & (idx == IDX_MASK_B)) begin
      mask_b_nxt = wb_dat_i[7:0];
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      validity_timing_select_r <= 1'b0;
      parity_error_policy_r <= POL_IGNORE;
      err_en_r <= RST_ERR_SRC; // [RULE_17]
      mask_a_r <= RST_MASK; // [RULE_16]
      mask_b_r <= RST_MASK; // [RULE_16]
      pin_mode_r <= {PIN_FLAG, PIN_FLAG}; // [RULE_13]
      output_format_select_r <= RST_FMT;
    end else begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
      if (bus_req & wb_we_i & wb_sel_i[0]) begin
        case (idx)
          IDX_VALID_TIMING: validity_timing_select_r <= wb_dat_i[0];
          IDX_PARITY_POL: parity_error_policy_r <= wb_dat_i[1:0];
          IDX_ERR_SRC: err_en_r <= {2'h0, wb_dat_i[5:0]};
          IDX_PIN_MODE: pin_mode_r <= wb_dat_i[3:0];
          IDX_FMT: output_format_select_r <= wb_dat_i[2:0];
          default: ;
        endcase
      end
    end
  end

  // Frame numbering and non-PCM detection from channel status bit 1
  assign fidx_nxt = smp_block_start ? 8'h0 : ((fidx_r == FRAME_LAST) ? 8'h0 : fidx_r + 8'h1); // [RULE_06]
  always_ff @(posedge clk) begin
    if (srst) begin
      fidx_r <= FRAME_LAST;
      nonaudio_flag <= 1'b0;
    end else if (smp_valid & ~smp_right) begin
      fidx_r <= fidx_nxt; // [RULE_06]
      if (fidx_nxt == CS_NONAUDIO_BIT) begin
        nonaudio_flag <= smp_c; // [RULE_09]
      end
    end
  end

  // Concealment covers PCM under policy 01, everything under 10; 00 and 11 pass data
  assign conceal_on = (parity_error_policy_r == POL_ALL) | ((parity_error_policy_r == POL_PCM) & ~nonaudio_flag); // [RULE_09] [RULE_11] [RULE_12]
  always_comb begin
    conceal = smp_data; // [RULE_12]
    if (conceal_on & smp_parity_err) begin
      if (err_run_r >= ERR_RUN_LIMIT) begin
        conceal = 24'h0; // [RULE_10]
      end else begin
        conceal = smp_right ? good_r_r : good_l_r; // [RULE_08]
      end
    end
  end

  // Error run counter, mute state and last good samples
  always_ff @(posedge clk) begin
    if (srst) begin
      err_run_r <= 4'h0;
      mute_r <= 1'b0;
      good_l_r <= 24'h0;
      good_r_r <= 24'h0;
    end else if (smp_valid) begin
      if (smp_parity_err & conceal_on) begin
        if (err_run_r >= ERR_RUN_LIMIT) begin
          mute_r <= 1'b1; // [RULE_10] [RULE_11]
        end else begin
          err_run_r <= err_run_r + 4'h1;
        end
      end else if (~smp_parity_err) begin
        err_run_r <= 4'h0; // [RULE_21]
        mute_r <= 1'b0; // [RULE_21]
        if (smp_right) begin
          good_r_r <= smp_data;
        end else begin
          good_l_r <= smp_data;
        end
      end
    end
  end

  // Samples and side bits wait here for the next frame start
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_l_r <= 24'h0;
      pend_r_r <= 24'h0;
      pend_cuv_l_r <= 3'h0;
      pend_cuv_r_r <= 3'h0;
      pend_bs_r <= 1'b0;
      last_v_r <= 1'b0;
      last_perr_r <= 1'b0;
    end else begin
      // A consumed block start is dropped so the flag runs once; a new one in the same cycle wins
      if (bck_fall & (slot_nxt == 6'h0)) begin
        pend_bs_r <= 1'b0; // [RULE_05]
      end
      if (smp_valid) begin
        last_v_r <= smp_v;
        last_perr_r <= smp_parity_err;
        if (smp_right) begin
          pend_r_r <= conceal;
          pend_cuv_r_r <= {smp_c, smp_u, smp_v};
        end else begin
          pend_l_r <= conceal;
          pend_cuv_l_r <= {smp_c, smp_u, smp_v};
          pend_bs_r <= smp_block_start;
        end
      end
    end
  end

  // Bit clock: three flops, a fall counts when the second is low and the third still high
  always_ff @(posedge clk) begin
    if (srst) begin
      bck_sync_r <= 3'h0;
    end else begin
      bck_sync_r <= {bck_sync_r[1:0], rx_bit_clk};
    end
  end
  assign bck_fall = ~bck_sync_r[1] & bck_sync_r[2];
  assign slot_nxt = slot_r + 6'h1;

  // Effective format and first data slot
  always_comb begin
    case (output_format_select_r)
      FMT_RJ24: begin
        fmt_eff = FMT_RJ24; // [RULE_01]
        start_slot = SLOT_RJ24;
      end
      FMT_RJ16: begin
        fmt_eff = FMT_RJ16; // [RULE_01]
        start_slot = SLOT_RJ16;
      end
      FMT_LJ24: begin
        fmt_eff = FMT_LJ24; // [RULE_01]
        start_slot = SLOT_LJ;
      end
      default: begin
        fmt_eff = FMT_I2S; // [RULE_01] [RULE_20]
        start_slot = SLOT_I2S;
      end
    endcase
  end

  // Slot counter, frame clock and serial shifter, all moved on the bit clock fall
  always_ff @(posedge clk) begin
    if (srst) begin
      slot_r <= 6'h3f;
      recovered_frame_clock_out <= 1'b0;
      shift_r <= 24'h0;
      serial_data_out <= 1'b0;
    end else if (bck_fall) begin
      slot_r <= slot_nxt;
      recovered_frame_clock_out <= (fmt_eff == FMT_I2S) ? slot_nxt[5] : ~slot_nxt[5]; // [RULE_04]
      if (slot_nxt[4:0] == start_slot) begin
        // Load the half's word; 16-bit mode keeps the top sixteen bits
        serial_data_out <= slot_nxt[5] ? out_r_r[23] : out_l_r[23]; // [RULE_02]
        if (fmt_eff == FMT_RJ16) begin
          shift_r <= {(slot_nxt[5] ? out_r_r[22:8] : out_l_r[22:8]), 9'h0};
        end else begin
          shift_r <= {(slot_nxt[5] ? out_r_r[22:0] : out_l_r[22:0]), 1'b0};
        end
      end else begin
        serial_data_out <= shift_r[23]; // [RULE_02]
        shift_r <= {shift_r[22:0], 1'b0};
      end
    end
  end

  // Frame start: take the waiting pair and run the block flag
  always_ff @(posedge clk) begin
    if (srst) begin
      out_l_r <= 24'h0;
      out_r_r <= 24'h0;
      cuv_l_r <= 3'h0;
      cuv_r_r <= 3'h0;
      blk_cnt_r <= 3'h0;
      block_start_flag <= 1'b0;
    end else if (bck_fall & (slot_nxt == 6'h0)) begin
      out_l_r <= pend_l_r;
      out_r_r <= pend_r_r;
      cuv_l_r <= pend_cuv_l_r;
      cuv_r_r <= pend_cuv_r_r;
      if (pend_bs_r) begin
        block_start_flag <= 1'b1; // [RULE_05]
        blk_cnt_r <= BLK_FLAG_FRAMES;
      end else if (blk_cnt_r == 3'h0) begin
        block_start_flag <= 1'b0; // [RULE_05]
      end else begin
        blk_cnt_r <= blk_cnt_r - 3'h1;
      end
    end
  end

  // C and U change with each half; V per the timing select
  always_ff @(posedge clk) begin
    if (srst) begin
      channel_status_out <= 1'b0;
      user_bits_out <= 1'b0;
      validity_out <= 1'b0;
    end else begin
      if (bck_fall & (slot_nxt[4:0] == 5'h0)) begin
        channel_status_out <= slot_nxt[5] ? cuv_r_r[2] : cuv_l_r[2]; // [RULE_03]
        user_bits_out <= slot_nxt[5] ? cuv_r_r[1] : cuv_l_r[1]; // [RULE_03]
        if (validity_timing_select_r) begin
          validity_out <= slot_nxt[5] ? cuv_r_r[0] : cuv_l_r[0]; // [RULE_07]
        end
      end
      if (~validity_timing_select_r & smp_valid) begin
        validity_out <= smp_v; // [RULE_07]
      end
    end
  end

  // Receiver error flag
  assign err_flag = (err_en_r[ERRB_UNLOCK] & pll_unlock) | (err_en_r[ERRB_PARITY] & last_perr_r)
    | (err_en_r[ERRB_VALID] & last_v_r) | (err_en_r[ERRB_NONAUDIO] & nonaudio_flag)
    | (err_en_r[ERRB_LIMIT] & rate_out_of_range) | (err_en_r[ERRB_RATE] & rate_change_ev); // [RULE_17]

  // Interrupt events; analog crossing only reaches line b
  assign ev_a = {1'b0, rate_change_ev, burst_update_ev, cs_update_ev, surround_ev, emphasis_ev,
    nonaudio_flag & ~nonaudio_d_r, err_flag & ~err_flag_d_r}; // [RULE_18]
  assign ev_b = {analog_level_ev, ev_a[6:0]}; // [RULE_18]
  // A read clears everything, but an event in the same cycle survives
  assign stat_a_nxt = (rd_a ? 8'h0 : stat_a_r) | ev_a; // [RULE_15]
  assign stat_b_nxt = (rd_b ? 8'h0 : stat_b_r) | ev_b; // [RULE_15]

  // Pending bits and interrupt levels
  always_ff @(posedge clk) begin
    if (srst) begin
      err_flag_d_r <= 1'b0;
      nonaudio_d_r <= 1'b0;
      stat_a_r <= 8'h0;
      stat_b_r <= 8'h0;
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      err_flag_d_r <= err_flag;
      nonaudio_d_r <= nonaudio_flag;
      stat_a_r <= stat_a_nxt;
      stat_b_r <= stat_b_nxt;
      irq_a_r <= |(stat_a_nxt & ~mask_a_nxt); // [RULE_14]
      irq_b_r <= |(stat_b_nxt & ~mask_b_nxt); // [RULE_14]
    end
  end

  // Status pins: flag, interrupt line or released
  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_line_a <= 1'b0;
      interrupt_line_b <= 1'b0;
      interrupt_line_a_oe_n <= 1'b0;
      interrupt_line_b_oe_n <= 1'b0;
    end else begin
      interrupt_line_a <= (pin_mode_r[1:0] == PIN_IRQ) ? irq_a_r : err_flag_d_r; // [RULE_13]
      interrupt_line_b <= (pin_mode_r[3:2] == PIN_IRQ) ? irq_b_r : nonaudio_d_r; // [RULE_13]
      interrupt_line_a_oe_n <= (pin_mode_r[1:0] == PIN_HIZ); // [RULE_13]
      interrupt_line_b_oe_n <= (pin_mode_r[3:2] == PIN_HIZ); // [RULE_13]
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_stat_a_read;
    rd_a & ~(|ev_a);
  endsequence
  property p_read_clears;
    s_stat_a_read ##1 (mask_a_r == mask_a_nxt) |-> ##0 (stat_a_r == 8'h0) ##1 !irq_a_r || |stat_a_r;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear line a"); // [RULE_15]

  property p_irq_or;
    irq_a_r == |(stat_a_r & ~mask_a_r);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("line a interrupt not OR of unmasked bits"); // [RULE_14]

  property p_mask_reset;
    $fell(srst) |-> (mask_a_r == 8'hff) && (mask_b_r == 8'hff) && !irq_a_r && !irq_b_r;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("masks not all set after reset"); // [RULE_16]

  property p_mute_after_run;
    smp_valid && smp_parity_err && conceal_on && err_run_r == 4'd8 |=> mute_r;
  endproperty
  a_mute_after_run: assert property (p_mute_after_run) else $error("no mute after eight errors"); // [RULE_10]

  property p_repeat_good;
    smp_valid && smp_parity_err && conceal_on && err_run_r < 4'd8 && !smp_right
      |=> pend_l_r == $past(good_l_r);
  endproperty
  a_repeat_good: assert property (p_repeat_good) else $error("bad sample not replaced by last good"); // [RULE_08]

  property p_pass_ignore;
    smp_valid && parity_error_policy_r == 2'h0 && smp_right |=> pend_r_r == $past(smp_data);
  endproperty
  a_pass_ignore: assert property (p_pass_ignore) else $error("policy 00 altered a sample"); // [RULE_12]

  property p_nonaudio_pass;
    smp_valid && nonaudio_flag && parity_error_policy_r == 2'h1 && !smp_right |=> pend_l_r == $past(smp_data);
  endproperty
  a_nonaudio_pass: assert property (p_nonaudio_pass) else $error("non-PCM sample altered"); // [RULE_09]

  property p_fmt_default;
    !(output_format_select_r inside {3'h0, 3'h3, 3'h5}) |-> fmt_eff == 3'h4 && start_slot == 5'h01;
  endproperty
  a_fmt_default: assert property (p_fmt_default) else $error("unlisted format not I2S"); // [RULE_20]

  property p_frame_wrap;
    smp_valid && !smp_right && !smp_block_start && fidx_r == 8'd191 |=> fidx_r == 8'd0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame number did not wrap after 191"); // [RULE_06]

  property p_blk_hold;
    bck_fall && slot_nxt == 6'h0 && pend_bs_r |=> block_start_flag && blk_cnt_r == 3'd7;
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block flag not started for eight frames"); // [RULE_05]
endmodule : sroei_core
`default_nettype wire

// >>> core/sroei_pkg.sv
// Shared constants for the biphase receiver output, error and interrupt block.
// Assumes a word-wide classic Wishbone slave; register byte address is four times the index.
`default_nettype none
package sroei_pkg;
  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_VALID_TIMING = 8'h22; // Validity timing control
  localparam logic [7:0] IDX_PARITY_POL = 8'h23; // Parity policy control
  localparam logic [7:0] IDX_ERR_SRC = 8'h25; // Error source select
  localparam logic [7:0] IDX_MASK_A = 8'h2a; // Interrupt mask, line a
  localparam logic [7:0] IDX_MASK_B = 8'h2b; // Interrupt mask, line b
  localparam logic [7:0] IDX_STAT_A = 8'h2c; // Interrupt status, line a, clear on read
  localparam logic [7:0] IDX_STAT_B = 8'h2d; // Interrupt status, line b, clear on read
  localparam logic [7:0] IDX_PIN_MODE = 8'h2e; // Status pin function select
  localparam logic [7:0] IDX_FMT = 8'h2f; // Output format control
  localparam logic [7:0] IDX_FRAME_STAT = 8'h30; // Frame index and concealment state
  // Reset values
  localparam logic [7:0] RST_ERR_SRC = 8'h01; // Only unlock enabled
  localparam logic [7:0] RST_MASK = 8'hff; // All sources masked
  localparam logic [2:0] RST_FMT = 3'h4; // 24-bit I2S
  // Output format codes
  localparam logic [2:0] FMT_RJ24 = 3'h0; // 24-bit right-justified
  localparam logic [2:0] FMT_RJ16 = 3'h3; // 16-bit right-justified
  localparam logic [2:0] FMT_I2S = 3'h4; // 24-bit I2S
  localparam logic [2:0] FMT_LJ24 = 3'h5; // 24-bit left-justified
  // First bit slot of the word inside a 32-slot half frame
  localparam logic [4:0] SLOT_I2S = 5'h01; // One slot after the frame clock edge
  localparam logic [4:0] SLOT_LJ = 5'h00; // On the frame clock edge
  localparam logic [4:0] SLOT_RJ24 = 5'h08; // 32 minus 24
  localparam logic [4:0] SLOT_RJ16 = 5'h10; // 32 minus 16
  // Parity policy codes
  localparam logic [1:0] POL_IGNORE = 2'h0; // Pass everything
  localparam logic [1:0] POL_PCM = 2'h1; // Repeat then mute, PCM only
  localparam logic [1:0] POL_ALL = 2'h2; // Repeat then mute, all data
  // Error source enable bit positions
  localparam int ERRB_UNLOCK = 0; // PLL unlock
  localparam int ERRB_PARITY = 1; // Parity error
  localparam int ERRB_VALID = 2; // Validity bit set
  localparam int ERRB_NONAUDIO = 3; // Non-PCM data
  localparam int ERRB_LIMIT = 4; // Out-of-range rate
  localparam int ERRB_RATE = 5; // Rate change
  // Pin function codes
  localparam logic [1:0] PIN_FLAG = 2'h0; // Direct flag
  localparam logic [1:0] PIN_IRQ = 2'h1; // Interrupt line
  localparam logic [1:0] PIN_HIZ = 2'h2; // Released
  // Framing and concealment counts
  localparam logic [7:0] FRAME_LAST = 8'd191; // Last frame of a block
  localparam logic [7:0] CS_NONAUDIO_BIT = 8'd1; // Channel status bit marking non-PCM
  localparam logic [3:0] ERR_RUN_LIMIT = 4'd8; // Errors repeated before muting
  localparam logic [2:0] BLK_FLAG_FRAMES = 3'd7; // Frames after the first that keep the flag
endpackage : sroei_pkg
`default_nettype wire

// >>> testbench/sroei_host_model.sv
// Host-side model: makes the 64fs bit clock and shifts in serial audio.
// Assumes the data pin is sampled on the rising bit clock edge.
`default_nettype none
module sroei_host_model (
  output logic bit_clk, // Recovered bit clock, 80 ns period
  input wire logic sdata, // Serial audio data
  output logic [31:0] shift_r // Last 32 bits captured
);
  timeunit 1ns;
  timeprecision 1ps;
  // Audio bit clock runs free
  initial begin
    bit_clk = 1'b0;
    forever #40 bit_clk = ~bit_clk;
  end
  // Capture MSB first on the rising edge
  always_ff @(posedge bit_clk) begin
    shift_r <= {shift_r[30:0], sdata};
  end
endmodule : sroei_host_model
`default_nettype wire

// >>> testbench/tb_sroei_core.sv
// Self-checking bench for the receiver output and interrupt block.
// Assumes a one-cycle Wishbone answer and the host model as bit clock source.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sroei_core;
  timeunit 1ns;
  timeprecision 1ps;
  import sroei_pkg::*;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack, sdo, fck, bclk, sv = 0, unl = 0, bs = 0;
  logic sr = 0, pe = 0; // Right channel and parity error of the offered sample
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, rdat, sh;
  logic [23:0] sd = 0;
  logic [5:0] ev = 0; // Rate, emphasis, surround, cs, burst, analog pulses
  logic fa, fa_oe_n, fb, fb_oe_n, blk;
  int n_fail = 0, total_checks = 0;
  logic [31:0] q; // Last read word
  sroei_core sroei_core_inst (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_bit_clk(bclk),
    .smp_valid(sv), .smp_right(sr), .smp_data(sd), .smp_parity_err(pe), .smp_c(1'b0), .smp_u(1'b0),
    .smp_v(1'b0), .smp_block_start(bs), .pll_unlock(unl), .rate_out_of_range(1'b0), .rate_change_ev(ev[5]),
    .emphasis_ev(ev[4]), .surround_ev(ev[3]), .cs_update_ev(ev[2]), .burst_update_ev(ev[1]),
    .analog_level_ev(ev[0]), .serial_data_out(sdo), .recovered_frame_clock_out(fck),
    .channel_status_out(), .user_bits_out(), .validity_out(), .block_start_flag(blk),
    .interrupt_line_a(fa), .interrupt_line_a_oe_n(fa_oe_n), .interrupt_line_b(fb),
    .interrupt_line_b_oe_n(fb_oe_n));
  sroei_host_model sroei_host_model_inst (.bit_clk(bclk), .sdata(sdo), .shift_r(sh));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // One classic Wishbone cycle; held until ack is sampled high
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    if (ack !== 1'b1) n_fail++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Waits for the frame clock to change to the given level
  task automatic wait_fck(input logic lvl);
    logic p, o;
    int n;
    p = fck;
    n = 0;
    do begin @(posedge clk); o = p; p = fck; n++; end while (!(o === ~lvl && p === lvl) && n < 3000);
    if (n >= 3000) n_fail++;
  endtask : wait_fck
  task automatic t_reset_regs();
    wb(IDX_MASK_A, 0, 0); `CHK(q, RST_MASK)
    wb(IDX_MASK_B, 0, 0); `CHK(q, RST_MASK)
    wb(IDX_ERR_SRC, 0, 0); `CHK(q, RST_ERR_SRC)
    wb(IDX_FMT, 0, 0); `CHK(q[2:0], RST_FMT)
    wb(8'h10, 0, 0); `CHK(q, 8'h00)
  endtask : t_reset_regs
  // Unlock drives the error flag pin, then release the pin
  task automatic t_pins();
    unl <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK({fa, fa_oe_n}, 2'b10)
    unl <= 1'b0;
    wb(IDX_PIN_MODE, 1, {4'h0, PIN_IRQ, PIN_HIZ});
    repeat (3) @(posedge clk);
    `CHK(fa_oe_n, 1'b1)
  endtask : t_pins
  // All events fire; only channel status update is unmasked on line a
  task automatic t_irq();
    wb(IDX_PIN_MODE, 1, {4'h0, PIN_IRQ, PIN_IRQ});
    wb(IDX_MASK_A, 1, 8'hef);
    ev <= 6'h3f;
    @(posedge clk);
    ev <= 6'h00;
    repeat (4) @(posedge clk);
    `CHK({fa, fb}, 2'b10)
    wb(IDX_STAT_A, 0, 0); `CHK(q[7:2], 6'h1f)
    repeat (3) @(posedge clk);
    `CHK(fa, 1'b0)
    wb(IDX_STAT_A, 0, 0); `CHK(q, 8'h00)
  endtask : t_irq
  // Left sample in I2S sits one slot after the frame clock edge
  task automatic t_serial();
    @(posedge clk);
    sd <= 24'ha5c3f1;
    sv <= 1'b1;
    bs <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    bs <= 1'b0;
    repeat (3) wait_fck(1'b1);
    `CHK(sh[30:7], 24'ha5c3f1)
    `CHK(blk, 1'b1)
    repeat (5) wait_fck(1'b1);
    `CHK(blk, 1'b1)
    repeat (2) wait_fck(1'b1);
    `CHK(blk, 1'b0)
  endtask : t_serial
  // Policy 01: bad samples repeat the last good one, eight in a row then mute, a good one releases
  task automatic t_conceal();
    wb(IDX_PARITY_POL, 1, {6'h0, POL_PCM});
    sd <= 24'h123456;
    pe <= 1'b1;
    sv <= 1'b1;
    @(posedge clk);
    sr <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    sr <= 1'b0;
    repeat (3) wait_fck(1'b1);
    `CHK(sh[30:7], 24'ha5c3f1)
    wb(IDX_FRAME_STAT, 0, 0); `CHK(q[17:12], 6'h02)
    sv <= 1'b1;
    repeat (8) @(posedge clk);
    sv <= 1'b0;
    wb(IDX_FRAME_STAT, 0, 0); `CHK(q[17:12], 6'h28)
    pe <= 1'b0;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    wb(IDX_FRAME_STAT, 0, 0); `CHK(q[17:12], 6'h00)
  endtask : t_conceal
  // Left-justified: left half is frame clock high, word starts on the edge
  task automatic t_fmt();
    wb(IDX_FMT, 1, {5'h0, FMT_LJ24});
    repeat (3) wait_fck(1'b0);
    `CHK(sh[31:8], 24'h123456)
  endtask : t_fmt
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset_regs();
    t_pins();
    t_irq();
    t_serial();
    t_conceal();
    t_fmt();
    wrap_up();
  end
endmodule : tb_sroei_core
`default_nettype wire
